// ### hdl/trc_data_trace.sv
// Data trace unit: samples I/O bits and words into a circular trace memory.
// Assumes all inputs come from logic on clk_sys_in; a strobe port reaches the registers.
// Behaviour
// RULE1: Fixed mode samples once per period of 10 to 2550 ms in 10 ms steps.
// RULE2: Each sample holds up to 31 masked bits and up to 6 words.
// RULE3: Trace memory holds 4000 words shared by bits and words.
// RULE4: Sampling starts only after parameters load and a start command arrives.
// RULE5: After the trigger, samples past the delay are stored until memory fills.
// RULE6: Delay counts sampling periods from the trigger bit turning on.
// RULE7: Delay range shrinks with word count, from -1999..2000 down to -499..500.
// RULE8: Positive delay stores later samples; negative keeps samples before the trigger.
// RULE9: Configuring party sets nonzero period and omits the sample instruction there.
// RULE10: Once-per-cycle mode samples refresh data at each scan cycle end.
// RULE11: Instruction mode samples once per instruction execution after the trigger.
// RULE12: Only the programming device sets the sampling start bit.
// RULE13: Pre-trigger samples circulate; the pointer freezes at the post-trigger count.
`timescale 1ns/1ps
`include "trc_defs.svh"
module trc_data_trace #(
    parameter int TICK_CYC = `TRC_TICK_NS / `TRC_CLK_NS
) (
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        sampling_start_bit_in,
    input  wire logic        trace_trigger_bit_in,
    input  wire logic        scan_end_in,
    input  wire logic        trace_sample_instruction_in,
    input  wire logic [30:0] io_bits_in,
    input  wire logic [95:0] io_words_in,
    output logic             trace_busy_out,
    output logic             trace_done_out
);
    // Samples that fit for a given word count.
    function automatic logic [11:0] cap_of(input logic [2:0] n);
        logic [12:0] w;
        w = 13'(`TRC_MEM_WORDS);
        case (n)
            3'h0: cap_of = 12'(w / (`TRC_BIT_WORDS + 0));
            3'h1: cap_of = 12'(w / (`TRC_BIT_WORDS + 1));
            3'h2: cap_of = 12'(w / (`TRC_BIT_WORDS + 2));
            3'h3: cap_of = 12'(w / (`TRC_BIT_WORDS + 3));
            3'h4: cap_of = 12'(w / (`TRC_BIT_WORDS + 4));
            3'h5: cap_of = 12'(w / (`TRC_BIT_WORDS + 5));
            default: cap_of = 12'(w / (`TRC_BIT_WORDS + `TRC_MAX_WORDS));
        endcase
    endfunction : cap_of

    trc_pkg::trc_state_type state_q, state_d;
    logic [1:0]  mode_q, mode_d;
    logic [7:0]  period_q, period_d;
    logic [2:0]  nw_q, nw_d;
    logic [30:0] mask_q, mask_d;
    logic [11:0] delay_q, delay_d;
    logic        loaded_q, loaded_d;
    logic [17:0] tick_q, tick_d;
    logic [7:0]  per_q, per_d;
    logic        trig_q, start_q;
    logic [11:0] wptr_q, wptr_d;
    logic [11:0] ring_q, ring_d;
    logic [11:0] cap_q, cap_d;
    logic [11:0] target_q, target_d;
    logic [11:0] post_q, post_d;
    logic [3:0]  wcnt_q, wcnt_d;
    logic [2:0]  widx_q, widx_d;
    logic [15:0] snap_q [`TRC_REC_MAX];
    logic [15:0] snap_d [`TRC_REC_MAX];
    logic        ovr_q, ovr_d;
    logic [11:0] raddr_q, raddr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] mem_q [`TRC_MEM_WORDS];

    logic        busy, tick_p, evt, collect, accept, trig_rise, start_req;
    logic [11:0] ncap;
    logic signed [13:0] dlo, dhi, dsx, dcl;
    logic [30:0] mbits;

    assign busy      = wcnt_q != 4'h0;
    assign tick_p    = tick_q == 18'(TICK_CYC - 1);
    assign trig_rise = trace_trigger_bit_in && !trig_q;
    assign mbits     = io_bits_in & mask_q;

    always_comb begin
        case (mode_q)
            `TRC_MODE_FIX: evt = tick_p && period_q != 8'h00 && per_q == period_q - 8'h01; // RULE1
            `TRC_MODE_CYC: evt = scan_end_in; // RULE10
            `TRC_MODE_INS: evt = trace_sample_instruction_in; // RULE11
            default:       evt = 1'b0;
        endcase
    end

    // Instruction mode has no pre-trigger samples, so it only collects after the trigger.
    assign collect = (state_q == trc_pkg::TRC_ARMED && mode_q != `TRC_MODE_INS)
                   || (state_q == trc_pkg::TRC_POST && post_q != target_q); // RULE11 RULE5
    assign accept  = evt && collect && !busy;
    assign start_req = ((reg_wr_in && reg_addr_in == `TRC_A_CTRL && reg_wdata_in[`TRC_CTRL_START])
                     || (sampling_start_bit_in && !start_q)) && loaded_q; // RULE4 RULE12

    // Cycles since the trace was started or the last sampling event, kept only to check the fixed period.
    // A parameter write mid-trace makes the count meaningless, so it stays invalid until the next start.
    logic [31:0] gap_q, gap_d;
    logic        gap_v_q, gap_v_d;
    logic        start_go;

    assign start_go = start_req && (state_q == trc_pkg::TRC_IDLE || state_q == trc_pkg::TRC_DONE);

    always_comb begin
        gap_d   = (evt || start_go) ? 32'h00000000 : gap_q + 32'h00000001;
        gap_v_d = gap_v_q;
        if (reg_wr_in && reg_addr_in == `TRC_A_CFG) begin
            gap_v_d = 1'b0;
        end
        if (start_go) begin
            gap_v_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            gap_q   <= 32'h00000000;
            gap_v_q <= 1'b0;
        end else begin
            gap_q   <= gap_d;
            gap_v_q <= gap_v_d;
        end
    end

    // Clamp delay to the window that the chosen word count allows.
    always_comb begin
        ncap = cap_of(nw_q);
        dhi  = $signed({2'h0, ncap});
        dlo  = 14'sh1 - dhi;
        dsx  = 14'($signed(delay_q));
        if (dsx < dlo) begin
            dcl = dlo; // RULE7
        end else if (dsx > dhi) begin
            dcl = dhi; // RULE7
        end else begin
            dcl = dsx;
        end
    end

    always_comb begin
        state_d  = state_q;
        mode_d   = mode_q;
        period_d = period_q;
        nw_d     = nw_q;
        mask_d   = mask_q;
        delay_d  = delay_q;
        loaded_d = loaded_q;
        tick_d   = tick_p ? 18'h00000 : tick_q + 18'h00001;
        per_d    = per_q;
        wptr_d   = wptr_q;
        ring_d   = ring_q;
        cap_d    = cap_q;
        target_d = target_q;
        post_d   = post_q;
        wcnt_d   = wcnt_q;
        widx_d   = widx_q;
        snap_d   = snap_q;
        ovr_d    = ovr_q || (evt && collect && busy);
        raddr_d  = raddr_q;
        if (tick_p) begin
            per_d = (per_q == period_q - 8'h01) ? 8'h00 : per_q + 8'h01; // RULE1
        end
        if (busy) begin
            wptr_d = (wptr_q == ring_q - 12'h001) ? 12'h000 : wptr_q + 12'h001; // RULE13 RULE3
            widx_d = widx_q + 3'h1;
            wcnt_d = wcnt_q - 4'h1;
        end
        if (accept) begin
            snap_d[0] = mbits[15:0]; // RULE2
            snap_d[1] = {1'b0, mbits[30:16]};
            for (int i = 0; i < `TRC_MAX_WORDS; i++) begin
                snap_d[i + `TRC_BIT_WORDS] = io_words_in[i * 16 +: 16];
            end
            wcnt_d = 4'(nw_q) + 4'(`TRC_BIT_WORDS);
            widx_d = 3'h0;
        end
        case (state_q)
            trc_pkg::TRC_ARMED: begin
                if (trig_rise) begin
                    state_d = trc_pkg::TRC_POST; // RULE6
                    post_d  = accept ? 12'h001 : 12'h000;
                end
            end
            trc_pkg::TRC_POST: begin
                if (accept) begin
                    post_d = post_q + 12'h001; // RULE6 RULE8
                end
                if (post_q == target_q && !busy) begin
                    state_d = trc_pkg::TRC_DONE; // RULE5 RULE13
                end
            end
            trc_pkg::TRC_IDLE, trc_pkg::TRC_DONE: begin
            end
            default: state_d = trc_pkg::TRC_IDLE;
        endcase
        if (reg_wr_in) begin
            case (reg_addr_in)
                `TRC_A_CFG: begin
                    mode_d   = reg_wdata_in[`TRC_MODE_LSB +: 2];
                    period_d = reg_wdata_in[`TRC_PER_LSB +: 8];
                    nw_d     = (reg_wdata_in[`TRC_NW_LSB +: 3] > 3'(`TRC_MAX_WORDS))
                             ? 3'(`TRC_MAX_WORDS) : reg_wdata_in[`TRC_NW_LSB +: 3]; // RULE2
                    loaded_d = 1'b1; // RULE4
                end
                `TRC_A_MASK:  mask_d  = reg_wdata_in[30:0];
                `TRC_A_DELAY: delay_d = reg_wdata_in[11:0];
                `TRC_A_RADDR: raddr_d = reg_wdata_in[11:0];
                `TRC_A_CTRL: begin
                    if (reg_wdata_in[`TRC_CTRL_STOP]) begin
                        state_d = trc_pkg::TRC_IDLE;
                        wcnt_d  = 4'h0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (start_req && (state_q == trc_pkg::TRC_IDLE || state_q == trc_pkg::TRC_DONE)) begin
            state_d  = trc_pkg::TRC_ARMED; // RULE4
            cap_d    = ncap;
            ring_d   = 12'(ncap * (12'(nw_q) + 12'(`TRC_BIT_WORDS))); // RULE3
            target_d = 12'(dcl + dhi); // RULE7 RULE8
            wptr_d   = 12'h000;
            post_d   = 12'h000;
            wcnt_d   = 4'h0;
            ovr_d    = 1'b0;
            tick_d   = 18'h00000;
            per_d    = 8'h00;
        end
        if (reg_rd_in && reg_addr_in == `TRC_A_RDATA) begin
            raddr_d = (raddr_q == 12'(`TRC_MEM_WORDS - 1)) ? 12'h000 : raddr_q + 12'h001;
        end
    end

    always_comb begin
        rdata_d = 32'h00000000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `TRC_A_CFG:   rdata_d = {13'h0000, nw_q, period_q, 6'h00, mode_q};
                `TRC_A_MASK:  rdata_d = {1'b0, mask_q};
                `TRC_A_DELAY: rdata_d = 32'($signed(delay_q));
                `TRC_A_STAT:  rdata_d = {8'h00, post_q, 6'h00, loaded_q, ovr_q, state_q};
                `TRC_A_PTR:   rdata_d = {4'h0, target_q, 4'h0, wptr_q};
                `TRC_A_RADDR: rdata_d = {20'h00000, raddr_q};
                `TRC_A_RDATA: rdata_d = {16'h0000, mem_q[raddr_q]};
                default:      rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q  <= trc_pkg::TRC_IDLE;
            mode_q   <= `TRC_MODE_FIX;
            period_q <= 8'h00;
            nw_q     <= 3'h0;
            mask_q   <= 31'h00000000;
            delay_q  <= 12'h000;
            loaded_q <= 1'b0;
            tick_q   <= 18'h00000;
            per_q    <= 8'h00;
            trig_q   <= 1'b0;
            start_q  <= 1'b0;
            wptr_q   <= 12'h000;
            ring_q   <= 12'h001;
            cap_q    <= 12'h000;
            target_q <= 12'h000;
            post_q   <= 12'h000;
            wcnt_q   <= 4'h0;
            widx_q   <= 3'h0;
            ovr_q    <= 1'b0;
            raddr_q  <= 12'h000;
            rdata_q  <= 32'h00000000;
            for (int i = 0; i < `TRC_REC_MAX; i++) begin
                snap_q[i] <= 16'h0000;
            end
        end else begin
            state_q  <= state_d;
            mode_q   <= mode_d;
            period_q <= period_d;
            nw_q     <= nw_d;
            mask_q   <= mask_d;
            delay_q  <= delay_d;
            loaded_q <= loaded_d;
            tick_q   <= tick_d;
            per_q    <= per_d;
            trig_q   <= trace_trigger_bit_in;
            start_q  <= sampling_start_bit_in;
            wptr_q   <= wptr_d;
            ring_q   <= ring_d;
            cap_q    <= cap_d;
            target_q <= target_d;
            post_q   <= post_d;
            wcnt_q   <= wcnt_d;
            widx_q   <= widx_d;
            ovr_q    <= ovr_d;
            raddr_q  <= raddr_d;
            rdata_q  <= rdata_d;
            snap_q   <= snap_d;
        end
    end

    // Trace memory is left uncleared by reset; only written words are meaningful.
    always_ff @(posedge clk_sys_in) begin
        if (busy) begin
            mem_q[wptr_q] <= snap_q[widx_q]; // RULE3 RULE13
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign trace_busy_out = state_q == trc_pkg::TRC_ARMED || state_q == trc_pkg::TRC_POST;
    assign trace_done_out = state_q == trc_pkg::TRC_DONE;

    AST_FIX_PERIOD: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE1
        evt && mode_q == `TRC_MODE_FIX && gap_v_q |-> gap_q == 32'(period_q) * 32'(TICK_CYC) - 32'h00000001)
        else $error("Fixed sample off period.");
    AST_BITS_HIGH: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE2
        busy && widx_q == 3'h1 |-> !snap_q[1][15])
        else $error("Bit word 1 top bit set.");
    AST_RING_BOUND: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE3
        state_q != trc_pkg::TRC_IDLE |-> ring_q <= 12'(`TRC_MEM_WORDS) && wptr_q < ring_q)
        else $error("Write pointer outside trace memory.");
    AST_START_LOADED: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE4
        $rose(state_q == trc_pkg::TRC_ARMED) |-> $past(loaded_q))
        else $error("Armed without parameters.");
    AST_DONE_FULL: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE5
        $rose(state_q == trc_pkg::TRC_DONE) |-> post_q == target_q && !busy)
        else $error("Done before window filled.");
    AST_TRIG_POST: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE6
        state_q == trc_pkg::TRC_ARMED && trig_rise && !(reg_wr_in && reg_addr_in == `TRC_A_CTRL)
        |=> state_q == trc_pkg::TRC_POST)
        else $error("Trigger not taken.");
    AST_DELAY_RANGE: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE7
        state_q == trc_pkg::TRC_ARMED |-> target_q >= 12'h001 && target_q <= 12'(cap_q * 12'h002))
        else $error("Window target outside range.");
    AST_FREEZE: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE13
        state_q == trc_pkg::TRC_DONE && !start_req |=> $stable(wptr_q))
        else $error("Pointer moved after trace end.");
    AST_CYC_SAMPLE: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE10
        mode_q == `TRC_MODE_CYC && scan_end_in && collect && !busy
        && !(reg_wr_in && reg_addr_in == `TRC_A_CTRL) |=> busy)
        else $error("Scan end sample missed.");
    AST_INS_PRE: assert property (@(posedge clk_sys_in) disable iff (srst_in) // RULE11
        mode_q == `TRC_MODE_INS && state_q == trc_pkg::TRC_ARMED |-> !accept)
        else $error("Instruction sample before trigger.");

    COV_TRIG: cover property (@(posedge clk_sys_in) state_q == trc_pkg::TRC_ARMED ##1 state_q == trc_pkg::TRC_POST);
    COV_DONE: cover property (@(posedge clk_sys_in) $rose(state_q == trc_pkg::TRC_DONE));
    COV_WRAP: cover property (@(posedge clk_sys_in) busy && wptr_q == ring_q - 12'h001);
    COV_OVR:  cover property (@(posedge clk_sys_in) $rose(ovr_q));
endmodule : trc_data_trace

// ### hdl/trc_defs.svh
// Register map, field positions and timing figures of the data trace unit.
// Assumes inclusion by every design file that needs these figures.
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH
`define TRC_A_CTRL      8'h00
`define TRC_A_CFG       8'h04
`define TRC_A_MASK      8'h08
`define TRC_A_DELAY     8'h0C
`define TRC_A_STAT      8'h10
`define TRC_A_PTR       8'h14
`define TRC_A_RADDR     8'h18
`define TRC_A_RDATA     8'h1C
`define TRC_CTRL_START  0
`define TRC_CTRL_STOP   1
`define TRC_MODE_LSB    0
`define TRC_PER_LSB     8
`define TRC_NW_LSB      16
`define TRC_MODE_FIX    2'h0
`define TRC_MODE_CYC    2'h1
`define TRC_MODE_INS    2'h2
`define TRC_MEM_WORDS   4000
`define TRC_BIT_WORDS   2
`define TRC_MAX_WORDS   6
`define TRC_REC_MAX     8
`define TRC_NBITS       31
`define TRC_CLK_NS      50
`define TRC_TICK_NS     10000000
`endif

// ### hdl/trc_pkg.sv
// Types shared by the data trace unit.
// Assumes trc_defs.svh supplies the figures.
package trc_pkg;
    typedef enum logic [3:0] {
        TRC_IDLE  = 4'h1,
        TRC_ARMED = 4'h2,
        TRC_POST  = 4'h4,
        TRC_DONE  = 4'h8
    } trc_state_type;
endpackage : trc_pkg

// ### bench/trc_prog_model.sv
// Model of the programming device and user program driving the trace unit's event pins.
// Assumes the bench calls its tasks; every pin changes just after a rising edge.
`timescale 1ns/1ps
module trc_prog_model #(
    parameter logic [30:0] BITS  = 31'h0,
    parameter logic [15:0] WBASE = 16'h0
) (
    input  wire logic        clk_in,
    output logic             start_bit_out,
    output logic             trigger_bit_out,
    output logic             scan_end_out,
    output logic             instr_out,
    output logic      [30:0] io_bits_out,
    output logic      [95:0] io_words_out
);
    initial begin
        start_bit_out   = 1'b0;
        trigger_bit_out = 1'b0;
        scan_end_out    = 1'b0;
        instr_out       = 1'b0;
        io_bits_out     = BITS;
        for (int k = 0; k < 6; k++) begin
            io_words_out[16*k+:16] = WBASE + 16'(k);
        end
    end
    // Pulse 0 is the start bit, 2 a scan end, anything else one sampling instruction.
    task automatic pulse(input int which);
        @(posedge clk_in);
        case (which)
            0: start_bit_out <= 1'b1;
            2: scan_end_out <= 1'b1;
            default: instr_out <= 1'b1;
        endcase
        @(posedge clk_in);
        start_bit_out <= 1'b0;
        scan_end_out  <= 1'b0;
        instr_out     <= 1'b0;
    endtask : pulse
    task automatic trig(input logic level);
        @(posedge clk_in);
        trigger_bit_out <= level;
    endtask : trig
endmodule : trc_prog_model

// ### bench/testbench.sv
// Self-checking bench for the data trace unit.
// Assumes a short tick so that one 10 ms unit lasts only a few clocks.
`timescale 1ns/1ps
`include "trc_defs.svh"
module testbench;
    localparam int          TICK  = 4;
    localparam logic [30:0] BITS  = 31'h5A5A1234;
    localparam logic [15:0] WBASE = 16'hC0D0;
    logic        clk_sys_in = 1'b0;
    logic        srst_in    = 1'b1;
    logic [7:0]  addr       = 8'h00;
    logic [31:0] wdata      = 32'h0;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [31:0] rdata;
    logic        busy, done, st, tg, se, ins;
    logic [30:0] bits;
    logic [95:0] words;
    int          failures    = 0;
    int          comparisons = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    trc_prog_model #(.BITS(BITS), .WBASE(WBASE)) i_prog (.clk_in(clk_sys_in), .start_bit_out(st),
        .trigger_bit_out(tg), .scan_end_out(se), .instr_out(ins), .io_bits_out(bits), .io_words_out(words));
    trc_data_trace #(.TICK_CYC(TICK)) i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .sampling_start_bit_in(st), .trace_trigger_bit_in(tg), .scan_end_in(se),
        .trace_sample_instruction_in(ins), .io_bits_in(bits), .io_words_in(words),
        .trace_busy_out(busy), .trace_done_out(done));
    task automatic report_and_stop;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        check(d, e);
    endtask : rd_chk
    task automatic test_reset;
        rd_chk(`TRC_A_STAT, 32'h00000001);
        rd_chk(8'h20, 32'h0);
        rd_chk(`TRC_A_CTRL, 32'h0);
        wr_reg(`TRC_A_CTRL, 32'h00000001);
        i_prog.pulse(0);
        rd_chk(`TRC_A_STAT, 32'h00000001);
        check({31'h0, busy}, 32'h0);
    endtask : test_reset
    task automatic test_clamp;
        logic [31:0] d;
        int          cap;
        for (int nw = 0; nw <= 6; nw++) begin
            cap = 4000 / (2 + nw);
            wr_reg(`TRC_A_CFG, {13'h0, 3'(nw), 8'h01, 8'h02});
            wr_reg(`TRC_A_DELAY, 32'h000007FF);
            wr_reg(`TRC_A_CTRL, 32'h00000001);
            rd_reg(`TRC_A_PTR, d);
            check({20'h0, d[27:16]}, 32'(2 * cap));
            wr_reg(`TRC_A_CTRL, 32'h00000002);
            wr_reg(`TRC_A_DELAY, 32'(1 - cap));
            rd_chk(`TRC_A_DELAY, 32'(1 - cap));
            wr_reg(`TRC_A_CTRL, 32'h00000001);
            rd_reg(`TRC_A_PTR, d);
            check({20'h0, d[27:16]}, 32'h1);
            wr_reg(`TRC_A_CTRL, 32'h00000002);
        end
    endtask : test_clamp
    task automatic test_trace(input logic [1:0] mode, input int nw, input int target, input int per);
        logic [31:0] d, p0;
        int          cap, ring, n;
        cap  = 4000 / (2 + nw);
        ring = cap * (2 + nw);
        wr_reg(`TRC_A_CFG, {13'h0, 3'(nw), 8'(per), 6'h0, mode});
        wr_reg(`TRC_A_MASK, 32'h7FFF00FF);
        wr_reg(`TRC_A_DELAY, 32'(target - cap));
        i_prog.pulse(0);
        rd_reg(`TRC_A_STAT, d);
        check({28'h0, d[3:0]}, 32'h2);
        if (mode == `TRC_MODE_INS) begin
            rd_reg(`TRC_A_PTR, p0);
            check({20'h0, p0[11:0]}, 32'h0);
            i_prog.pulse(3);
            repeat (nw + 4) @(posedge clk_sys_in);
            rd_reg(`TRC_A_PTR, d);
            check({20'h0, d[11:0]}, {20'h0, p0[11:0]});
        end
        i_prog.trig(1'b1);
        if (mode != `TRC_MODE_FIX) begin
            for (int i = 0; i < target; i++) begin
                i_prog.pulse(mode == `TRC_MODE_CYC ? 2 : 3);
                repeat (nw + 3) @(posedge clk_sys_in);
            end
        end
        n = 0;
        // The state register is looked at just after the edge, once it has settled.
        while (done !== 1'b1 && n < 400) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        check({31'h0, done}, 32'h1);
        check({31'h0, busy}, 32'h0);
        if (mode == `TRC_MODE_FIX) begin
            check({31'h0, n >= (target - 1) * per * TICK && n <= target * per * TICK + nw + 6}, 32'h1);
        end
        rd_reg(`TRC_A_PTR, d);
        check({20'h0, d[27:16]}, 32'(target));
        wr_reg(`TRC_A_RADDR, 32'((int'(d[11:0]) + ring - (2 + nw)) % ring));
        rd_chk(`TRC_A_RDATA, {16'h0, BITS[15:0] & 16'h00FF});
        rd_chk(`TRC_A_RDATA, {17'h0, BITS[30:16]});
        for (int k = 0; k < nw; k++) begin
            rd_chk(`TRC_A_RDATA, {16'h0, WBASE + 16'(k)});
        end
        i_prog.trig(1'b0);
    endtask : test_trace
    task automatic test_overrun;
        logic [31:0] d;
        wr_reg(`TRC_A_CFG, {13'h0, 3'h6, 8'h01, 6'h0, `TRC_MODE_CYC});
        wr_reg(`TRC_A_CTRL, 32'h00000001);
        i_prog.pulse(2);
        i_prog.pulse(2);
        rd_reg(`TRC_A_STAT, d);
        check({31'h0, d[4]}, 32'h1);
        check({28'h0, d[3:0]}, 32'h2);
        wr_reg(`TRC_A_CTRL, 32'h00000002);
    endtask : test_overrun
    task automatic test_wrap;
        logic [31:0] d;
        wr_reg(`TRC_A_RADDR, 32'h00000F9F);
        rd_reg(`TRC_A_RDATA, d);
        rd_chk(`TRC_A_RADDR, 32'h0);
    endtask : test_wrap
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        test_reset();
        test_clamp();
        test_trace(`TRC_MODE_FIX, 1, 3, 2);
        test_trace(`TRC_MODE_CYC, 0, 1, 1);
        test_trace(`TRC_MODE_INS, 6, 2, 1);
        test_overrun();
        test_wrap();
        report_and_stop();
    end
endmodule : testbench
